// ### src/mst_translator.sv
// Microstep translator: step/direction pins to per-phase level, polarity and decay.
// Assumes all control pins are asynchronous to clk_sys; the ratio input is a
// converter sample already on clk_sys. Analog regulation lives outside.
`timescale 1ns/1ps

module mst_translator import mst_pkg::*; #(
  parameter logic [7:0] RES_MAP = MST_RES_MAP_DEF  // Select code to resolution
) (
  input  wire logic       clk_sys,             // 125 MHz system clock
  input  wire logic       arst_n,              // Asynchronous reset, active low
  input  wire logic       step_in,             // Advance strobe pin
  input  wire logic       dir_in,              // Rotation sense pin
  input  wire logic       resolution_sel_lo,   // Resolution select, low bit
  input  wire logic       resolution_sel_hi,   // Resolution select, high bit
  input  wire logic [7:0] fast_decay_ratio_in, // Ratio sample, fraction of supply
  input  wire logic       output_disable,      // High turns bridges off
  input  wire logic       power_down_n,        // Low enters power-down
  input  wire logic       logic_supply_low_lockout, // High while supply is low
  output mst_phase_s      phase_a,             // Phase A level, polarity, decay
  output mst_phase_s      phase_b,             // Phase B level, polarity, decay
  output logic            bridge_en,           // Bridges allowed to drive
  output logic [5:0]      position_idx         // Sixteenth index, zero based
);

  mst_state_s st_reg;
  mst_state_s st_next;
  logic       hold;
  logic       step_edge;
  logic [1:0] res;
  logic [5:0] inc;
  logic [5:0] idx_new;
  logic [1:0] pfd_cls;
  mst_phase_s pa_new;
  mst_phase_s pb_new;

  // Ratio classification, thresholds exclusive at both ends
  always_comb begin
    if (fast_decay_ratio_in > MST_PFD_SLOW_ABOVE) begin
      pfd_cls = MST_DEC_SLOW;
    end else if (fast_decay_ratio_in < MST_PFD_FAST_BELOW) begin
      pfd_cls = MST_DEC_FAST;
    end else begin
      pfd_cls = MST_DEC_MIXED;
    end
  end

  // Resolution from the synchronised selects, looked up through the map
  always_comb begin
    res = RES_MAP[{st_reg.sync2[MST_SYN_MSHI], st_reg.sync2[MST_SYN_MSLO], 1'b0} +: 2];
    case (res)
      MST_RES_FULL: inc = MST_INC_FULL;
      MST_RES_HALF: inc = MST_INC_HALF;
      MST_RES_8TH:  inc = MST_INC_8TH;
      default:      inc = MST_INC_16TH;
    endcase
  end

  // Next position and phase values; sine is cosine a quarter turn back
  always_comb begin
    logic [5:0] ib;
    ib = 6'h00;
    idx_new = st_reg.sync2[MST_SYN_DIR] ? st_reg.idx - inc : st_reg.idx + inc;
    ib      = idx_new - 6'h10;
    pa_new.level = mst_mag(idx_new[4] ? 5'h10 - {1'b0, idx_new[3:0]}
                                      : {1'b0, idx_new[3:0]});
    pa_new.neg   = idx_new[4] ^ idx_new[5];
    pb_new.level = mst_mag(ib[4] ? 5'h10 - {1'b0, ib[3:0]} : {1'b0, ib[3:0]});
    pb_new.neg   = ib[4] ^ ib[5];
    // Falling level takes the ratio mode, anything else stays slow
    pa_new.decay = (pa_new.level < st_reg.pa.level) ? pfd_cls : MST_DEC_SLOW;
    pb_new.decay = (pb_new.level < st_reg.pb.level) ? pfd_cls : MST_DEC_SLOW;
  end

  // Lockout and power-down both pin the translator at Home
  assign hold      = ~st_reg.sync2[MST_SYN_AWAKE] | st_reg.sync2[MST_SYN_LOCK];
  // Edge seen on the second flop only, never on the first
  assign step_edge = st_reg.sync2[MST_SYN_STEP] & ~st_reg.step_prev;

  // Next-state assembly
  always_comb begin
    st_next           = st_reg;
    st_next.sync1     = {step_in, dir_in, resolution_sel_hi, resolution_sel_lo,
                         output_disable, power_down_n, logic_supply_low_lockout};
    st_next.sync2     = st_reg.sync1;
    st_next.step_prev = st_reg.sync2[MST_SYN_STEP];
    st_next.stepped   = 1'b0;
    // Disable only gates the bridges; the translator below ignores it
    st_next.bridge_en = ~hold & ~st_reg.sync2[MST_SYN_DIS];
    if (hold) begin
      st_next.idx = MST_HOME_IDX;
      st_next.pa  = MST_PHASE_HOME;
      st_next.pb  = MST_PHASE_HOME;
    end else if (step_edge) begin
      st_next.idx     = idx_new;
      st_next.pa      = pa_new;
      st_next.pb      = pb_new;
      st_next.stepped = 1'b1;
    end
  end

  // Single state register; reset lands on Home
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= MST_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase_a      = st_reg.pa;
  assign phase_b      = st_reg.pb;
  assign bridge_en    = st_reg.bridge_en;
  assign position_idx = st_reg.idx;

  // Helpers for checks: what a strobe edge in this cycle should give
  logic [5:0] exp_cw;
  logic [5:0] exp_ccw;
  assign exp_cw  = st_reg.idx + inc;
  assign exp_ccw = st_reg.idx - inc;

  property p_home_levels;
    @(posedge clk_sys) disable iff (!arst_n)
      st_reg.idx == MST_HOME_IDX && !st_reg.stepped |->
        phase_a.level == MST_HOME_LVL && phase_b.level == MST_HOME_LVL && !phase_a.neg;
  endproperty
  a_home_levels: assert property (p_home_levels)
    else $error("home position without plus 70 percent levels");

  property p_home_mixed;
    @(posedge clk_sys) disable iff (!arst_n)
      hold |=> phase_a.decay == MST_DEC_MIXED && phase_b.decay == MST_DEC_MIXED;
  endproperty
  a_home_mixed: assert property (p_home_mixed)
    else $error("home state did not select mixed decay");

  property p_step_cw;
    @(posedge clk_sys) disable iff (!arst_n)
      step_edge && !hold && !st_reg.sync2[MST_SYN_DIR] |=> position_idx == $past(exp_cw);
  endproperty
  a_step_cw: assert property (p_step_cw)
    else $error("clockwise step did not add one increment");

  property p_step_ccw;
    @(posedge clk_sys) disable iff (!arst_n)
      step_edge && !hold && st_reg.sync2[MST_SYN_DIR] |=> position_idx == $past(exp_ccw);
  endproperty
  a_step_ccw: assert property (p_step_ccw)
    else $error("counterclockwise step did not subtract one increment");

  property p_no_edge_still;
    @(posedge clk_sys) disable iff (!arst_n)
      !step_edge && !hold |=> $stable(position_idx) ##1 1'b1;
  endproperty
  a_no_edge_still: assert property (p_no_edge_still)
    else $error("position moved without a strobe edge");

  property p_rise_slow;
    @(posedge clk_sys) disable iff (!arst_n)
      st_reg.stepped && phase_a.level >= $past(phase_a.level) |->
        phase_a.decay == MST_DEC_SLOW;
  endproperty
  a_rise_slow: assert property (p_rise_slow)
    else $error("rising phase level not in slow decay");

  property p_fall_ratio;
    @(posedge clk_sys) disable iff (!arst_n)
      st_reg.stepped && phase_b.level < $past(phase_b.level) |->
        phase_b.decay == $past(pfd_cls);
  endproperty
  a_fall_ratio: assert property (p_fall_ratio)
    else $error("falling phase level ignored the ratio input");

  property p_lockout_home;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(hold) |-> position_idx == MST_HOME_IDX ##1 position_idx[0] == 1'b0 || st_reg.stepped;
  endproperty
  a_lockout_home: assert property (p_lockout_home)
    else $error("translator not at home when lockout ended");

  property p_sleep_off;
    @(posedge clk_sys) disable iff (!arst_n)
      !st_reg.sync2[MST_SYN_AWAKE] |=> !bridge_en && position_idx == MST_HOME_IDX;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("power-down left bridges on or position away from home");

  property p_disable_steps;
    @(posedge clk_sys) disable iff (!arst_n)
      st_reg.sync2[MST_SYN_DIS] && step_edge && !hold |=> !bridge_en && st_reg.stepped;
  endproperty
  a_disable_steps: assert property (p_disable_steps)
    else $error("output disable stopped the translator");

  property p_quarter;
    @(posedge clk_sys) disable iff (!arst_n)
      position_idx == 6'h10 |-> phase_a.level == 8'h00 && phase_b.level == 8'hFF;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("90 degree point has wrong levels");

endmodule : mst_translator

// ### src/mst_pkg.sv
// Constants, carriers and sequence table of the microstep translator.
// Assumes a single 125 MHz system clock and a level code of 8 bits per phase.
package mst_pkg;

  // Sequence position: 64 sixteenth steps per electrical turn
  localparam int          MST_IDX_W    = 6;
  localparam logic [5:0]  MST_HOME_IDX = 6'h08;   // 45 degree point
  localparam logic [7:0]  MST_HOME_LVL = 8'hB4;   // 70.71 % of full scale

  // Resolution codes and index increment per step
  localparam logic [1:0]  MST_RES_FULL = 2'h0;
  localparam logic [1:0]  MST_RES_HALF = 2'h1;
  localparam logic [1:0]  MST_RES_8TH  = 2'h2;
  localparam logic [1:0]  MST_RES_16TH = 2'h3;
  localparam logic [5:0]  MST_INC_FULL = 6'h10;
  localparam logic [5:0]  MST_INC_HALF = 6'h08;
  localparam logic [5:0]  MST_INC_8TH  = 6'h02;
  localparam logic [5:0]  MST_INC_16TH = 6'h01;
  // Select code c picks resolution MST_RES_MAP_DEF[2c+:2]
  localparam logic [7:0]  MST_RES_MAP_DEF = 8'hE4;

  // Decay mode codes
  localparam logic [1:0]  MST_DEC_SLOW  = 2'h0;
  localparam logic [1:0]  MST_DEC_FAST  = 2'h1;
  localparam logic [1:0]  MST_DEC_MIXED = 2'h2;

  // Ratio input is a fraction of logic supply, 8'hFF = full supply
  localparam logic [7:0]  MST_PFD_SLOW_ABOVE = 8'h99;  // 0.6 of supply
  localparam logic [7:0]  MST_PFD_FAST_BELOW = 8'h36;  // 0.21 of supply

  // Bit positions of the synchronised pin vector
  localparam int          MST_SYN_W     = 7;
  localparam int          MST_SYN_STEP  = 6;
  localparam int          MST_SYN_DIR   = 5;
  localparam int          MST_SYN_MSHI  = 4;
  localparam int          MST_SYN_MSLO  = 3;
  localparam int          MST_SYN_DIS   = 2;
  localparam int          MST_SYN_AWAKE = 1;
  localparam int          MST_SYN_LOCK  = 0;

  // One phase towards its DAC and bridge
  typedef struct packed {
    logic [7:0] level;   // Magnitude, 8'hFF = 100 %
    logic       neg;     // Current polarity, 1 = negative
    logic [1:0] decay;   // Decay mode code
  } mst_phase_s;

  // Whole state of the translator
  typedef struct packed {
    logic [MST_SYN_W-1:0] sync1;
    logic [MST_SYN_W-1:0] sync2;
    logic                 step_prev;
    logic                 stepped;
    logic                 bridge_en;
    logic [5:0]           idx;
    mst_phase_s           pa;
    mst_phase_s           pb;
  } mst_state_s;

  localparam mst_phase_s MST_PHASE_HOME = '{level: MST_HOME_LVL, neg: 1'b0,
                                            decay: MST_DEC_MIXED};
  localparam mst_state_s MST_STATE_RST = '{sync1: '0, sync2: '0, step_prev: 1'b0,
                                           stepped: 1'b0, bridge_en: 1'b0,
                                           idx: MST_HOME_IDX,
                                           pa: MST_PHASE_HOME, pb: MST_PHASE_HOME};

  // Cosine of k * 5.625 degrees, k = 0..16, scaled to 255
  function automatic logic [7:0] mst_mag(input logic [4:0] k);
    case (k)
      5'h00:   mst_mag = 8'hFF;
      5'h01:   mst_mag = 8'hFE;
      5'h02:   mst_mag = 8'hFA;
      5'h03:   mst_mag = 8'hF4;
      5'h04:   mst_mag = 8'hEC;
      5'h05:   mst_mag = 8'hE1;
      5'h06:   mst_mag = 8'hD4;
      5'h07:   mst_mag = 8'hC5;
      5'h08:   mst_mag = 8'hB4;
      5'h09:   mst_mag = 8'hA2;
      5'h0A:   mst_mag = 8'h8E;
      5'h0B:   mst_mag = 8'h78;
      5'h0C:   mst_mag = 8'h62;
      5'h0D:   mst_mag = 8'h4A;
      5'h0E:   mst_mag = 8'h32;
      5'h0F:   mst_mag = 8'h19;
      default: mst_mag = 8'h00;
    endcase
  endfunction : mst_mag

endpackage : mst_pkg

// ### tb/mst_host_model.sv
// Host controller model: sets direction and resolution, then issues one strobe.
// Assumes the translator synchronises its pins; every level is held 3 cycles or more.
`timescale 1ns/1ps
module mst_host_model (
  input  wire logic clk_sys,            // System clock
  output logic      step_in,            // Advance strobe
  output logic      dir_in,             // Rotation sense
  output logic      resolution_sel_lo,  // Resolution select, low bit
  output logic      resolution_sel_hi   // Resolution select, high bit
);
  // Idle pins low from time zero
  initial begin
    step_in = 1'b0;
    dir_in = 1'b0;
    resolution_sel_lo = 1'b0;
    resolution_sel_hi = 1'b0;
  end

  // Moves only the level pins; no strobe, so nothing should advance
  task automatic set_levels(input logic dir, input logic [1:0] sel);
    @(posedge clk_sys);
    dir_in <= dir;
    resolution_sel_lo <= sel[0];
    resolution_sel_hi <= sel[1];
  endtask : set_levels

  // One strobe per increment; levels settle 3 cycles before the rise
  task automatic pulse(input logic dir, input logic [1:0] sel);
    set_levels(dir, sel);
    repeat (3) @(posedge clk_sys);
    step_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    step_in <= 1'b0;
    repeat (4) @(posedge clk_sys);  // Leaves room for sync plus register
  endtask : pulse
endmodule : mst_host_model

// ### tb/test_microstep_translator.sv
// Self-checking bench for the microstep translator with a host model at its pins.
// Assumes two-flop pin synchronisers and one output register; a second unit
// runs with the select map reversed so that the mapping itself is exercised.
`timescale 1ns/1ps
module test_microstep_translator import mst_pkg::*;;
  logic       clk_sys;
  logic       arst_n;
  logic       step_in;
  logic       dir_in;
  logic       resolution_sel_lo;
  logic       resolution_sel_hi;
  logic [7:0] fast_decay_ratio_in;
  logic       output_disable;
  logic       power_down_n;
  logic       logic_supply_low_lockout;
  mst_phase_s phase_a;
  mst_phase_s phase_b;
  logic       bridge_en;
  logic [5:0] position_idx;
  logic [5:0] alt_position_idx;
  int         errors;
  int         n_compared;
  int         exp_idx;
  int         exp_alt;
  logic [7:0] ratios [6] = '{8'h9A, 8'h99, 8'h36, 8'h35, 8'h00, 8'hFF};

  mst_translator mst_translator_i (.clk_sys(clk_sys), .arst_n(arst_n), .step_in(step_in),
    .dir_in(dir_in), .resolution_sel_lo(resolution_sel_lo),
    .resolution_sel_hi(resolution_sel_hi), .fast_decay_ratio_in(fast_decay_ratio_in),
    .output_disable(output_disable), .power_down_n(power_down_n),
    .logic_supply_low_lockout(logic_supply_low_lockout), .phase_a(phase_a),
    .phase_b(phase_b), .bridge_en(bridge_en), .position_idx(position_idx));
  mst_host_model mst_host_model_i (.clk_sys(clk_sys), .step_in(step_in), .dir_in(dir_in),
    .resolution_sel_lo(resolution_sel_lo), .resolution_sel_hi(resolution_sel_hi));
  // Second unit on the same pins, reversed map: code c picks resolution 3 - c
  mst_translator #(.RES_MAP(8'h1B)) mst_translator_alt_i (.clk_sys(clk_sys),
    .arst_n(arst_n), .step_in(step_in), .dir_in(dir_in),
    .resolution_sel_lo(resolution_sel_lo), .resolution_sel_hi(resolution_sel_hi),
    .fast_decay_ratio_in(fast_decay_ratio_in), .output_disable(output_disable),
    .power_down_n(power_down_n), .logic_supply_low_lockout(logic_supply_low_lockout),
    .phase_a(), .phase_b(), .bridge_en(), .position_idx(alt_position_idx));

  // 125 MHz clock
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // Polarity and magnitude of cosine at sixteenth index q, worked out independently
  function automatic logic [8:0] cos_code(input int q);
    int m;
    int k;
    m = q % 32;
    k = (m <= 16) ? m : 32 - m;
    cos_code[7:0] = 8'($rtoi(255.0 * $cos(k * 3.14159265358979 / 32.0) + 0.5));
    cos_code[8] = (q >= 16) && (q <= 47);
  endfunction : cos_code

  // Falling level takes the ratio class; otherwise slow
  function automatic logic [1:0] exp_decay(input logic [7:0] nw, pv, ratio);
    if (nw >= pv) return MST_DEC_SLOW;
    if (ratio > MST_PFD_SLOW_ABOVE) return MST_DEC_SLOW;
    if (ratio < MST_PFD_FAST_BELOW) return MST_DEC_FAST;
    return MST_DEC_MIXED;
  endfunction : exp_decay

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Index, levels, polarities and decays against the expected position
  task automatic chk_state(input logic [1:0] dec_a, input logic [1:0] dec_b);
    logic [8:0] ca;
    logic [8:0] cb;
    ca = cos_code(exp_idx);
    cb = cos_code((exp_idx + 48) % 64);
    chk(8'(position_idx), 8'(exp_idx), "index");
    chk(phase_a.level, ca[7:0], "level a");
    chk(phase_b.level, cb[7:0], "level b");
    chk(8'(phase_a.neg), 8'(ca[8]), "sign a");
    chk(8'(phase_b.neg), 8'(cb[8]), "sign b");
    chk(8'(phase_a.decay), 8'(dec_a), "decay a");
    chk(8'(phase_b.decay), 8'(dec_b), "decay b");
  endtask : chk_state

  // One step through the host model, then compare the new position
  task automatic do_step(input logic dir, input logic [1:0] sel, input logic [7:0] ratio);
    logic [8:0] pa;
    logic [8:0] pb;
    logic [8:0] na;
    logic [8:0] nb;
    int         inc;
    int         inc_alt;
    pa = cos_code(exp_idx);
    pb = cos_code((exp_idx + 48) % 64);
    case (sel)
      MST_RES_FULL: inc = int'(MST_INC_FULL);
      MST_RES_HALF: inc = int'(MST_INC_HALF);
      MST_RES_8TH:  inc = int'(MST_INC_8TH);
      default:      inc = int'(MST_INC_16TH);
    endcase
    // Reversed map of the second unit
    case (sel)
      2'h0:    inc_alt = int'(MST_INC_16TH);
      2'h1:    inc_alt = int'(MST_INC_8TH);
      2'h2:    inc_alt = int'(MST_INC_HALF);
      default: inc_alt = int'(MST_INC_FULL);
    endcase
    @(posedge clk_sys);
    fast_decay_ratio_in <= ratio;
    mst_host_model_i.pulse(dir, sel);
    exp_idx = dir ? (exp_idx - inc + 64) % 64 : (exp_idx + inc) % 64;
    exp_alt = dir ? (exp_alt - inc_alt + 64) % 64 : (exp_alt + inc_alt) % 64;
    na = cos_code(exp_idx);
    nb = cos_code((exp_idx + 48) % 64);
    chk_state(exp_decay(na[7:0], pa[7:0], ratio),
              exp_decay(nb[7:0], pb[7:0], ratio));
    chk(8'(alt_position_idx), 8'(exp_alt), "index alt map");
  endtask : do_step

  // Lets an asserted hold pin pass the synchroniser, strobes once, then expects Home
  task automatic hold_home();
    repeat (6) @(posedge clk_sys);
    chk(8'(bridge_en), 8'h00, "bridge off in hold");
    mst_host_model_i.pulse(1'b0, MST_RES_FULL);
    exp_idx = 8;
    exp_alt = 8;
    chk_state(MST_DEC_MIXED, MST_DEC_MIXED);
    chk(8'(alt_position_idx), 8'(MST_HOME_IDX), "home alt map");
  endtask : hold_home

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // Cut a hang short; the tests need about 1100 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    arst_n = 1'b0;
    fast_decay_ratio_in = 8'h80;
    output_disable = 1'b0;
    power_down_n = 1'b1;
    logic_supply_low_lockout = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    exp_idx = 8;
    exp_alt = 8;
    chk_state(MST_DEC_MIXED, MST_DEC_MIXED);
    chk(8'(alt_position_idx), 8'(MST_HOME_IDX), "home alt");
    chk(8'(bridge_en), 8'h01, "bridge on");
    $display("test home done");
    // Full turn and wrap at sixteenth step, ratio classes at their boundaries
    for (int i = 0; i < 66; i++) do_step(1'b0, MST_RES_16TH, ratios[i % 6]);
    $display("test sixteenth turn done");
    // Every select code in both directions
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 2; d++) begin
        repeat (2) do_step(d[0], s[1:0], ratios[s + d]);
      end
    end
    $display("test resolutions done");
    // Levels moved without a strobe leave the position alone
    mst_host_model_i.set_levels(1'b1, MST_RES_FULL);
    repeat (10) @(posedge clk_sys);
    chk(8'(position_idx), 8'(exp_idx), "no strobe");
    $display("test sampling done");
    output_disable <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(8'(bridge_en), 8'h00, "bridge disabled");
    do_step(1'b1, MST_RES_HALF, 8'h20);
    output_disable <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(8'(bridge_en), 8'h01, "bridge back");
    $display("test disable done");
    do_step(1'b0, MST_RES_8TH, 8'h50);
    logic_supply_low_lockout <= 1'b1;
    hold_home();
    logic_supply_low_lockout <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk_state(MST_DEC_MIXED, MST_DEC_MIXED);
    chk(8'(bridge_en), 8'h01, "bridge after lockout");
    $display("test lockout done");
    do_step(1'b1, MST_RES_16TH, 8'h50);
    power_down_n <= 1'b0;
    hold_home();
    power_down_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_state(MST_DEC_MIXED, MST_DEC_MIXED);
    chk(8'(bridge_en), 8'h01, "bridge after wake");
    do_step(1'b0, MST_RES_FULL, 8'h10);
    $display("test power down done");
    close_out();
  end
endmodule : test_microstep_translator
